/* File: src/ssc_safe_stop.v */
// safe stop controller: stop sequencing, ramp supervision and axi4-lite registers
//
// What this block does
// - falling edge on either cat1 input starts cat1
// - falling edge on either cat2 input starts cat2
// - two ramp-select bits choose one of four ramps
// - rising reset edge returns block to normal operation
// - inhibit high suppresses cat0 on invalid speed
// - torque enable: 0 removes torque, 1 permits
// - brake enable: 0 cuts brake power, 1 releases
// - amplifier off: 0 shuts amplifier, 1 permits
// - stop request: 0 asks drive ramp, 1 none
// - ramp active high while stop ramp monitored
// - status reports torque removed by bad motion
// - status forced 1 while motion data invalid
// - status starts at 1 on entering run
// - reset possible high when reset is acceptable
// - speed monitored to decrease until standstill
// - ramp start delayed 0 to 248 ms, 4 ms steps
// - cat1 brake and torque off delays after amp off
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "ssc_map.vh"
module ssc_safe_stop #(
	parameter TICK_CYCLES = `SSC_STEP_MS * `SSC_CLK_KHZ
) (
	input wire clock_in,
	input wire reset_in,
	input wire [15:0] speed_in,
	input wire speed_valid_in,
	input wire stop_cat1_request_a_in,
	input wire stop_cat1_request_b_in,
	input wire stop_cat2_request_a_in,
	input wire stop_cat2_request_b_in,
	input wire [1:0] ramp_select_in,
	input wire reset_request_in,
	input wire fault_inhibit_in,
	output wire torque_enable_out,
	output wire brake_enable_out,
	output wire amplifier_on_out,
	output wire stop_none_out,
	output wire ramp_active_out,
	output wire status_out,
	output wire reset_possible_out,
	input wire [7:0] s_axi_awaddr_in,
	input wire s_axi_awvalid_in,
	output wire s_axi_awready_out,
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	input wire s_axi_wvalid_in,
	output wire s_axi_wready_out,
	output wire [1:0] s_axi_bresp_out,
	output wire s_axi_bvalid_out,
	input wire s_axi_bready_in,
	input wire [7:0] s_axi_araddr_in,
	input wire s_axi_arvalid_in,
	output wire s_axi_arready_out,
	output wire [31:0] s_axi_rdata_out,
	output wire [1:0] s_axi_rresp_out,
	output wire s_axi_rvalid_out,
	input wire s_axi_rready_in
);
	localparam ST_RUN = 3'h0;
	localparam ST_DELAY = 3'h1;
	localparam ST_RAMP = 3'h2;
	localparam ST_OFF1 = 3'h3;
	localparam ST_HOLD2 = 3'h4;
	localparam ST_FAULT = 3'h5;

	// =====================================================
	// pin synchronisers and edge detection
	reg [6:0] sync1_r;
	reg [6:0] sync2_r;
	reg [6:0] prev_r;
	wire [6:0] pins = {fault_inhibit_in, reset_request_in, stop_cat2_request_b_in, stop_cat2_request_a_in,
		stop_cat1_request_b_in, stop_cat1_request_a_in, 1'b0};

	always @(posedge clock_in) begin
		if (reset_in) begin
			sync1_r <= 7'h1E;
			sync2_r <= 7'h1E;
			prev_r <= 7'h1E;
		end else begin
			sync1_r <= pins;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	reg [1:0] sel1_r;
	reg [1:0] sel2_r;
	always @(posedge clock_in) begin
		if (reset_in) begin
			sel1_r <= 2'h0;
			sel2_r <= 2'h0;
		end else begin
			sel1_r <= ramp_select_in;
			sel2_r <= sel1_r;
		end
	end

	wire cat1_fall = (prev_r[1] & ~sync2_r[1]) | (prev_r[2] & ~sync2_r[2]);
	wire cat2_fall = (prev_r[3] & ~sync2_r[3]) | (prev_r[4] & ~sync2_r[4]);
	wire cat1_high = sync2_r[1] & sync2_r[2];
	wire cat1_rise = cat1_high & ~(prev_r[1] & prev_r[2]);
	wire reset_rise = sync2_r[5] & ~prev_r[5];
	wire inhibit = sync2_r[6];

	// =====================================================
	// step tick
	reg [16:0] tick_cnt_r;
	wire tick = (tick_cnt_r == TICK_CYCLES[16:0] - 17'h00001);
	always @(posedge clock_in) begin
		if (reset_in || tick)
			tick_cnt_r <= 17'h00000;
		else
			tick_cnt_r <= tick_cnt_r + 17'h00001;
	end

	// =====================================================
	// configuration registers
	reg [31:0] delay_r;
	reg [31:0] offdly_r;
	reg [31:0] still_r;
	reg [31:0] ramp01_r;
	reg [31:0] ramp23_r;
	reg [31:0] offset_r;

	function [5:0] clamp_steps;
		input [5:0] s;
		begin
			clamp_steps = (s > `SSC_MAX_STEPS) ? `SSC_MAX_STEPS : s;
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
		end
	endfunction

	wire [5:0] delay_steps = clamp_steps(delay_r[5:0]);
	wire [5:0] brake_steps = clamp_steps(offdly_r[`SSC_OFF_BRAKE_LSB +: `SSC_STEP_W]);
	wire [5:0] torque_steps = clamp_steps(offdly_r[`SSC_OFF_TORQUE_LSB +: `SSC_STEP_W]);

	// =====================================================
	// stop state machine
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg cat1_r;
	reg cat1_nxt;
	reg [1:0] ramp_sel_r;
	reg [1:0] ramp_sel_nxt;
	reg [16:0] limit_r;
	reg [16:0] limit_nxt;
	reg torque_r;
	reg brake_r;
	reg amp_r;
	reg stop_r;
	reg ramp_r;
	reg status_r;
	reg resposs_r;
	wire delay_done;
	wire brake_done;
	wire torque_done;

	wire [15:0] steep = (ramp_sel_r == 2'h0) ? ramp01_r[15:0] : (ramp_sel_r == 2'h1) ? ramp01_r[31:16] :
		(ramp_sel_r == 2'h2) ? ramp23_r[15:0] : ramp23_r[31:16];
	wire [16:0] speed17 = {1'b0, speed_in};
	wire at_still = speed_in <= still_r[15:0];
	wire bad_data = ~speed_valid_in & ~inhibit;
	wire reset_ok = resposs_r & (reset_rise | cat1_rise);

	always @* begin
		state_nxt = state_r;
		cat1_nxt = cat1_r;
		ramp_sel_nxt = ramp_sel_r;
		limit_nxt = limit_r;
		case (state_r)
			ST_RUN: begin
				if (cat1_fall || cat2_fall) begin
					state_nxt = ST_DELAY;
					cat1_nxt = cat1_fall;
					ramp_sel_nxt = sel2_r;
				end
			end
			ST_DELAY: begin
				if (cat1_fall)
					cat1_nxt = 1'b1;
				if (delay_done) begin
					state_nxt = ST_RAMP;
					limit_nxt = speed17 + {1'b0, offset_r[15:0]};
				end
			end
			ST_RAMP: begin
				if (cat1_fall)
					cat1_nxt = 1'b1;
				if (speed_valid_in && speed17 > limit_r)
					state_nxt = ST_FAULT;
				else if (speed_valid_in && at_still)
					state_nxt = (cat1_r || cat1_fall) ? ST_OFF1 : ST_HOLD2;
				else if (tick)
					limit_nxt = (limit_r > {1'b0, steep}) ? limit_r - {1'b0, steep} : 17'h00000;
			end
			ST_OFF1: begin
				if (reset_ok)
					state_nxt = ST_RUN;
			end
			ST_HOLD2: begin
				if (cat1_fall) begin
					state_nxt = ST_OFF1;
					cat1_nxt = 1'b1;
				end else if (speed_valid_in && !at_still)
					state_nxt = ST_FAULT;
				else if (reset_ok)
					state_nxt = ST_RUN;
			end
			ST_FAULT: begin
				if (reset_ok)
					state_nxt = ST_RUN;
			end
			default: state_nxt = ST_FAULT;
		endcase
		// unreliable speed escalates straight to torque-off except in a cycle that accepts a reset, which returns to run first
		if (bad_data && state_nxt != ST_RUN)
			state_nxt = ST_FAULT;
		if (bad_data && state_r == ST_RUN)
			state_nxt = ST_FAULT;
	end

	wire load_delay = (state_r == ST_RUN) && (state_nxt == ST_DELAY);
	wire load_off = (state_r != ST_OFF1) && (state_nxt == ST_OFF1);

	ssc_step_timer u_delay (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.load_in(load_delay),
		.tick_in(tick),
		.steps_in(delay_steps),
		.done_out(delay_done)
	);

	ssc_step_timer u_brake (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.load_in(load_off),
		.tick_in(tick),
		.steps_in(brake_steps),
		.done_out(brake_done)
	);

	ssc_step_timer u_torque (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.load_in(load_off),
		.tick_in(tick),
		.steps_in(torque_steps),
		.done_out(torque_done)
	);

	// =====================================================
	// drive outputs, all registered
	wire in_off1 = (state_nxt == ST_OFF1);
	wire in_fault = (state_nxt == ST_FAULT);
	// off delays run only after amp off falls, so load_off cycle still shows enables high
	wire torque_nxt = ~in_fault & ~(in_off1 & ~load_off & torque_done);
	wire brake_nxt = ~in_fault & ~(in_off1 & ~load_off & brake_done);
	wire amp_nxt = ~in_fault & ~in_off1;
	wire stop_nxt = (state_nxt == ST_RUN);
	wire ramp_nxt = (state_nxt == ST_DELAY) || (state_nxt == ST_RAMP);
	wire status_nxt = ~speed_valid_in | ~in_fault;
	wire resposs_nxt = cat1_high && (((state_nxt == ST_OFF1) && torque_done && brake_done && !load_off) ||
		(state_nxt == ST_HOLD2) || (state_nxt == ST_FAULT));

	always @(posedge clock_in) begin
		if (reset_in) begin
			state_r <= ST_RUN;
			cat1_r <= 1'b0;
			ramp_sel_r <= 2'h0;
			limit_r <= 17'h00000;
			torque_r <= 1'b1;
			brake_r <= 1'b1;
			amp_r <= 1'b1;
			stop_r <= 1'b1;
			ramp_r <= 1'b0;
			status_r <= 1'b1;
			resposs_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cat1_r <= cat1_nxt;
			ramp_sel_r <= ramp_sel_nxt;
			limit_r <= limit_nxt;
			torque_r <= torque_nxt;
			brake_r <= brake_nxt;
			amp_r <= amp_nxt;
			stop_r <= stop_nxt;
			ramp_r <= ramp_nxt;
			status_r <= status_nxt;
			resposs_r <= resposs_nxt;
		end
	end

	assign torque_enable_out = torque_r;
	assign brake_enable_out = brake_r;
	assign amplifier_on_out = amp_r;
	assign stop_none_out = stop_r;
	assign ramp_active_out = ramp_r;
	assign status_out = status_r;
	assign reset_possible_out = resposs_r;

	// =====================================================
	// axi4-lite slave, one write and one read at a time
	reg aw_rdy_r;
	reg w_rdy_r;
	reg aw_have_r;
	reg w_have_r;
	reg [7:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	reg bvalid_r;
	reg [1:0] bresp_r;
	reg ar_rdy_r;
	reg rvalid_r;
	reg [31:0] rdata_r;
	reg [1:0] rresp_r;
	wire do_write = aw_have_r & w_have_r & ~bvalid_r;
	wire wr_ok = (aw_addr_r == `SSC_REG_DELAY) || (aw_addr_r == `SSC_REG_OFFDLY) ||
		(aw_addr_r == `SSC_REG_STILL) || (aw_addr_r == `SSC_REG_RAMP01) ||
		(aw_addr_r == `SSC_REG_RAMP23) || (aw_addr_r == `SSC_REG_OFFSET);
	wire [31:0] status_word = {17'h00000, resposs_r, status_r, ramp_r, stop_r, amp_r, brake_r, torque_r,
		5'h00, state_r};

	always @(posedge clock_in) begin
		if (reset_in) begin
			aw_rdy_r <= 1'b0;
			w_rdy_r <= 1'b0;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `SSC_RESP_OKAY;
			delay_r <= `SSC_RST_DELAY;
			offdly_r <= `SSC_RST_OFFDLY;
			still_r <= `SSC_RST_STILL;
			ramp01_r <= `SSC_RST_RAMP01;
			ramp23_r <= `SSC_RST_RAMP23;
			offset_r <= `SSC_RST_OFFSET;
		end else begin
			if (s_axi_awvalid_in && aw_rdy_r) begin
				aw_rdy_r <= 1'b0;
				aw_have_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr_in[7:2], 2'h0};
			end else if (!aw_have_r && !bvalid_r) begin
				aw_rdy_r <= 1'b1;
			end
			if (s_axi_wvalid_in && w_rdy_r) begin
				w_rdy_r <= 1'b0;
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata_in;
				w_strb_r <= s_axi_wstrb_in;
			end else if (!w_have_r && !bvalid_r) begin
				w_rdy_r <= 1'b1;
			end
			if (do_write) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_ok ? `SSC_RESP_OKAY : `SSC_RESP_SLVERR;
				case (aw_addr_r)
					`SSC_REG_DELAY: delay_r <= merge(delay_r, w_data_r, w_strb_r);
					`SSC_REG_OFFDLY: offdly_r <= merge(offdly_r, w_data_r, w_strb_r);
					`SSC_REG_STILL: still_r <= merge(still_r, w_data_r, w_strb_r);
					`SSC_REG_RAMP01: ramp01_r <= merge(ramp01_r, w_data_r, w_strb_r);
					`SSC_REG_RAMP23: ramp23_r <= merge(ramp23_r, w_data_r, w_strb_r);
					`SSC_REG_OFFSET: offset_r <= merge(offset_r, w_data_r, w_strb_r);
					default: bresp_r <= `SSC_RESP_SLVERR;
				endcase
			end else if (bvalid_r && s_axi_bready_in) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always @(posedge clock_in) begin
		if (reset_in) begin
			ar_rdy_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `SSC_RESP_OKAY;
		end else if (s_axi_arvalid_in && ar_rdy_r) begin
			ar_rdy_r <= 1'b0;
			rvalid_r <= 1'b1;
			rresp_r <= `SSC_RESP_OKAY;
			case ({s_axi_araddr_in[7:2], 2'h0})
				`SSC_REG_DELAY: rdata_r <= delay_r;
				`SSC_REG_OFFDLY: rdata_r <= offdly_r;
				`SSC_REG_STILL: rdata_r <= still_r;
				`SSC_REG_RAMP01: rdata_r <= ramp01_r;
				`SSC_REG_RAMP23: rdata_r <= ramp23_r;
				`SSC_REG_OFFSET: rdata_r <= offset_r;
				`SSC_REG_STATUS: rdata_r <= status_word;
				default: begin
					rdata_r <= 32'h00000000;
					rresp_r <= `SSC_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r) begin
			if (s_axi_rready_in)
				rvalid_r <= 1'b0;
		end else begin
			ar_rdy_r <= 1'b1;
		end
	end

	assign s_axi_awready_out = aw_rdy_r;
	assign s_axi_wready_out = w_rdy_r;
	assign s_axi_bvalid_out = bvalid_r;
	assign s_axi_bresp_out = bresp_r;
	assign s_axi_arready_out = ar_rdy_r;
	assign s_axi_rvalid_out = rvalid_r;
	assign s_axi_rdata_out = rdata_r;
	assign s_axi_rresp_out = rresp_r;
endmodule

/* File: src/ssc_map.vh */
// register map, field layout, reset values and timing constants of the safe stop controller
`ifndef SSC_MAP_VH
`define SSC_MAP_VH

// =====================================================
// register byte offsets
`define SSC_ADDR_W 8
`define SSC_REG_DELAY 8'h00
`define SSC_REG_OFFDLY 8'h04
`define SSC_REG_STILL 8'h08
`define SSC_REG_RAMP01 8'h0C
`define SSC_REG_RAMP23 8'h10
`define SSC_REG_OFFSET 8'h14
`define SSC_REG_STATUS 8'h18

// =====================================================
// field positions
`define SSC_STEP_W 6
`define SSC_OFF_BRAKE_LSB 0
`define SSC_OFF_TORQUE_LSB 8
`define SSC_ST_STATE_LSB 0
`define SSC_ST_OUT_LSB 8

// =====================================================
// reset values
`define SSC_RST_DELAY 32'h00000000
`define SSC_RST_OFFDLY 32'h00000000
`define SSC_RST_STILL 32'h0000000A
`define SSC_RST_RAMP01 32'h00200010
`define SSC_RST_RAMP23 32'h00800040
`define SSC_RST_OFFSET 32'h00000000

// =====================================================
// timing
`define SSC_STEP_MS 4
`define SSC_CLK_KHZ 25000
`define SSC_MAX_STEPS 6'h3E

// =====================================================
// bus answers
`define SSC_RESP_OKAY 2'h0
`define SSC_RESP_SLVERR 2'h2

`endif

/* File: src/ssc_step_timer.v */
// delay timer counting 4 ms step ticks after a load, the first step possibly short
`timescale 1ns/10ps
module ssc_step_timer (
	input wire clock_in,
	input wire reset_in,
	input wire load_in,
	input wire tick_in,
	input wire [5:0] steps_in,
	output wire done_out
);
	reg [5:0] cnt_r;
	reg run_r;
	reg done_r;

	assign done_out = done_r;

	// first step may be short: granularity is one tick, not one load
	always @(posedge clock_in) begin
		if (reset_in) begin
			cnt_r <= 6'h00;
			run_r <= 1'b0;
			done_r <= 1'b0;
		end else if (load_in) begin
			cnt_r <= steps_in;
			run_r <= 1'b1;
			done_r <= 1'b0;
		end else if (run_r) begin
			if (cnt_r == 6'h00) begin
				run_r <= 1'b0;
				done_r <= 1'b1;
			end else if (tick_in) begin
				cnt_r <= cnt_r - 6'h01;
			end
		end
	end
endmodule

/* File: dv/ssc_safe_stop_sva.sv */
// assertion checker for the safe stop controller
`timescale 1ns/10ps
module ssc_safe_stop_sva (
	input wire clock_in,
	input wire reset_in,
	input wire stop_cat1_request_a_in,
	input wire stop_cat2_request_a_in,
	input wire reset_request_in,
	input wire speed_valid_in,
	input wire torque_enable_out,
	input wire brake_enable_out,
	input wire amplifier_on_out,
	input wire stop_none_out,
	input wire ramp_active_out,
	input wire status_out,
	input wire reset_possible_out,
	input wire s_axi_arvalid_in,
	input wire s_axi_arready_out,
	input wire s_axi_rvalid_out
);
	// ==========
	// properties
	// run seen from outputs only, so pin edges outside run are not judged
	wire run_w = stop_none_out & amplifier_on_out & torque_enable_out & ~ramp_active_out;
	default clocking dc @(posedge clock_in); endclocking
	default disable iff (reset_in);
	chk_reset_values: assert property (disable iff (1'b0)
		reset_in |=> torque_enable_out && brake_enable_out && amplifier_on_out && stop_none_out
		&& status_out && !ramp_active_out && !reset_possible_out) else $error("outputs wrong after reset");
	chk_cat1_start: assert property ($fell(stop_cat1_request_a_in) && run_w
		|-> ##[2:6] !stop_none_out && ramp_active_out) else $error("cat1 stop not started");
	chk_cat2_start: assert property ($fell(stop_cat2_request_a_in) && run_w
		|-> ##[2:6] !stop_none_out && ramp_active_out) else $error("cat2 stop not started");
	chk_ramp_stop: assert property (ramp_active_out |-> !stop_none_out)
		else $error("ramp active without stop request");
	chk_amp_first: assert property ($fell(torque_enable_out) || $fell(brake_enable_out)
		|-> !amplifier_on_out) else $error("enable dropped before amplifier off");
	chk_ramp_ends: assert property ($fell(amplifier_on_out) |-> !ramp_active_out)
		else $error("ramp still active at amplifier off");
	chk_fault_off: assert property ($fell(status_out)
		|-> !torque_enable_out && !brake_enable_out && !amplifier_on_out) else $error("fault left power on");
	chk_invalid_status: assert property (!speed_valid_in [*2] |-> status_out)
		else $error("status low while speed invalid");
	chk_reset_idle: assert property (reset_possible_out |-> !ramp_active_out)
		else $error("reset possible during ramp");
	chk_reset_return: assert property ($rose(reset_request_in) && reset_possible_out
		|-> ##[2:8] stop_none_out && torque_enable_out) else $error("reset not accepted");
	chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out
		|=> s_axi_rvalid_out && !s_axi_arready_out) else $error("read answer late");
	cover property ($fell(status_out));
	cover property ($fell(amplifier_on_out) && status_out);
	cover property ($rose(reset_possible_out));
endmodule

bind ssc_safe_stop ssc_safe_stop_sva u_sva (
	.clock_in(clock_in),
	.reset_in(reset_in),
	.stop_cat1_request_a_in(stop_cat1_request_a_in),
	.stop_cat2_request_a_in(stop_cat2_request_a_in),
	.reset_request_in(reset_request_in),
	.speed_valid_in(speed_valid_in),
	.torque_enable_out(torque_enable_out),
	.brake_enable_out(brake_enable_out),
	.amplifier_on_out(amplifier_on_out),
	.stop_none_out(stop_none_out),
	.ramp_active_out(ramp_active_out),
	.status_out(status_out),
	.reset_possible_out(reset_possible_out),
	.s_axi_arvalid_in(s_axi_arvalid_in),
	.s_axi_arready_out(s_axi_arready_out),
	.s_axi_rvalid_out(s_axi_rvalid_out)
);

/* File: dv/ssc_drive_model.sv */
// drive and encoder model facing the safe stop controller
`timescale 1ns/10ps
module ssc_drive_model #(
	parameter [15:0] NOMINAL = 16'h0200
) (
	input wire clock_in,
	input wire reset_in,
	input wire stop_none_in,
	input wire torque_enable_in,
	input wire [15:0] decel_in,
	output wire [15:0] speed_out
);
	// ==========
	// speed record
	reg [15:0] speed_r;
	assign speed_out = speed_r;
	// drive runs its own ramp on the early warning and also on torque loss
	always @(posedge clock_in) begin
		if (reset_in)
			speed_r <= NOMINAL;
		else if (!stop_none_in || !torque_enable_in)
			speed_r <= (speed_r > decel_in) ? speed_r - decel_in : 16'h0000;
		else if (speed_r < NOMINAL)
			speed_r <= speed_r + 16'h0004;
	end
endmodule

/* File: dv/ssc_safe_stop_tb.sv */
// testbench for the safe stop controller
`timescale 1ns/10ps
`include "ssc_map.vh"
module ssc_safe_stop_tb;
	// ==========
	// wiring
	reg clk = 1'h0, rst = 1'h1, vld = 1'h1, c1a = 1'h1, c1b = 1'h1, c2a = 1'h1, c2b = 1'h1, rreq = 1'h0, inh = 1'h0;
	reg [1:0] sel = 2'h0;
	reg [15:0] dec = 16'h0008;
	reg [7:0] awa = 8'h00, ara = 8'h00;
	reg [31:0] wd = 32'h0;
	reg [3:0] ws = 4'h0;
	reg awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
	wire [15:0] spd;
	wire [6:0] o;
	wire awr, wr, bv, arr, rv;
	wire [1:0] bresp, rresp;
	wire [31:0] rd;
	integer bad_count = 0, check_count = 0, cyc = 0, waited;
	always #20 clk = ~clk;
	ssc_drive_model u_drv (.clock_in(clk), .reset_in(rst), .stop_none_in(o[3]), .torque_enable_in(o[0]),
		.decel_in(dec), .speed_out(spd));
	ssc_safe_stop #(.TICK_CYCLES(10)) u_dut (.clock_in(clk), .reset_in(rst), .speed_in(spd), .speed_valid_in(vld),
		.stop_cat1_request_a_in(c1a), .stop_cat1_request_b_in(c1b), .stop_cat2_request_a_in(c2a),
		.stop_cat2_request_b_in(c2b), .ramp_select_in(sel), .reset_request_in(rreq), .fault_inhibit_in(inh),
		.torque_enable_out(o[0]), .brake_enable_out(o[1]), .amplifier_on_out(o[2]), .stop_none_out(o[3]),
		.ramp_active_out(o[4]), .status_out(o[5]), .reset_possible_out(o[6]),
		.s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
		.s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
		.s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rry));
	// ==========
	// shared tasks
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		begin
			check_count++;
			if (g !== e) begin
				bad_count++;
				$display("[FAIL] %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task summarize;
		begin
			$display("checks %0d mismatches %0d", check_count, bad_count);
			if (bad_count == 0 && check_count > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task wait_sig(input int k, input logic v);
		begin
			waited = 0;
			while (o[k] !== v && waited < 3000) begin
				@(posedge clk);
				waited++;
			end
		end
	endtask
	task axi_wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
		int n;
		begin
			awa <= a;
			wd <= d;
			ws <= s;
			awv <= 1'h1;
			wv <= 1'h1;
			bry <= 1'h1;
			n = 0;
			do begin
				@(posedge clk);
				if (awr) awv <= 1'h0;
				if (wr) wv <= 1'h0;
				n++;
			end while (bv !== 1'h1 && n < 50);
			cmp("bvalid", 1'h1, bv);
			cmp("bresp", er, bresp);
			bry <= 1'h0;
			@(posedge clk);
		end
	endtask
	task axi_rd(input [7:0] a, input [31:0] ed, input [1:0] er);
		int n;
		begin
			ara <= a;
			arv <= 1'h1;
			rry <= 1'h1;
			n = 0;
			do begin
				@(posedge clk);
				if (arr) arv <= 1'h0;
				n++;
			end while (rv !== 1'h1 && n < 50);
			cmp("rvalid", 1'h1, rv);
			cmp("rdata", ed, rd);
			cmp("rresp", er, rresp);
			rry <= 1'h0;
			@(posedge clk);
		end
	endtask
	// pins back high, then a reset request once reset is possible; a cat1 stop
	// only allows it after both off delays, so an early edge would be lost
	task rearm;
		begin
			c1a <= 1'h1;
			c1b <= 1'h1;
			c2a <= 1'h1;
			vld <= 1'h1;
			repeat (10) @(posedge clk);
			wait_sig(6, 1'h1);
			rreq <= 1'h1;
			@(posedge clk);
			wait_sig(3, 1'h1);
			cmp("reset accepted", 1'h1, o[3]);
			rreq <= 1'h0;
			repeat (150) @(posedge clk);
		end
	endtask
	// ==========
	// scenarios
	task t_reset;
		begin
			cmp("outputs after reset", 7'h2F, o);
			axi_rd(`SSC_REG_STATUS, 32'h00002F00, `SSC_RESP_OKAY);
		end
	endtask
	task t_regs;
		begin
			axi_rd(`SSC_REG_STILL, `SSC_RST_STILL, `SSC_RESP_OKAY);
			axi_rd(`SSC_REG_RAMP01, `SSC_RST_RAMP01, `SSC_RESP_OKAY);
			axi_rd(`SSC_REG_RAMP23, `SSC_RST_RAMP23, `SSC_RESP_OKAY);
			axi_wr(`SSC_REG_OFFDLY, 32'h00000502, 4'hF, `SSC_RESP_OKAY);
			axi_wr(`SSC_REG_OFFDLY, 32'hAAAA03FF, 4'h2, `SSC_RESP_OKAY);
			axi_rd(`SSC_REG_OFFDLY, 32'h00000302, `SSC_RESP_OKAY);
			axi_wr(`SSC_REG_DELAY, 32'h00000001, 4'hF, `SSC_RESP_OKAY);
			axi_rd(`SSC_REG_DELAY, 32'h00000001, `SSC_RESP_OKAY);
			axi_rd(8'h1C, 32'h0, `SSC_RESP_SLVERR);
			axi_wr(`SSC_REG_STATUS, 32'hFFFFFFFF, 4'hF, `SSC_RESP_SLVERR);
		end
	endtask
	task t_cat1;
		begin
			c1a <= 1'h0;
			wait_sig(3, 1'h0);
			cmp("stop request delay", 1, waited inside {[2:6]});
			cmp("ramp active", 1, o[4]);
			wait_sig(2, 1'h0);
			cmp("ramp after standstill", 0, o[4]);
			cmp("status normal stop", 1, o[5]);
			wait_sig(1, 1'h0);
			cmp("brake delay", 1, waited inside {[8:22]});
			wait_sig(0, 1'h0);
			cmp("torque after brake", 1, waited inside {[8:12]});
			rearm;
			cmp("run again", 7'h2F, o);
		end
	endtask
	// drive slower than the two steep ramps: those must end in a fault
	task t_ramps;
		int s;
		begin
			// offset keeps the free-running tick phase from tripping the shallow ramps
			axi_wr(`SSC_REG_OFFSET, 32'h00000030, 4'hF, `SSC_RESP_OKAY);
			dec <= 16'h0005;
			for (s = 0; s < 4; s++) begin
				sel <= s[1:0];
				@(posedge clk);
				c1b <= 1'h0;
				wait_sig(2, 1'h0);
				cmp("status at stop end", s < 2, o[5]);
				cmp("torque at stop end", s < 2, o[0]);
				rearm;
			end
			dec <= 16'h0008;
			sel <= 2'h0;
		end
	endtask
	task t_cat2;
		begin
			c2a <= 1'h0;
			wait_sig(3, 1'h0);
			cmp("cat2 ramp", 1, o[4]);
			wait_sig(4, 1'h0);
			repeat (20) @(posedge clk);
			cmp("cat2 hold", 7'h67, o);
			rearm;
			cmp("cat2 released", 7'h2F, o);
		end
	endtask
	task t_invalid;
		begin
			// inhibit crosses two sync flops, valid none: raise inhibit first
			inh <= 1'h1;
			repeat (4) @(posedge clk);
			vld <= 1'h0;
			repeat (20) @(posedge clk);
			cmp("inhibited invalid speed", 7'h2F, o);
			inh <= 1'h0;
			wait_sig(0, 1'h0);
			cmp("status while invalid", 1, o[5]);
			cmp("cat0 drop", 3'h0, o[2:0]);
			rearm;
		end
	endtask
	// ==========
	// main sequence and watchdog
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		repeat (3) @(posedge clk);
		t_reset;
		t_regs;
		t_cat1;
		t_ramps;
		t_cat2;
		t_invalid;
		summarize;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			summarize;
		end
	end
endmodule
